// File: rtl/eint_if.sv
// link between the control logic, a noise filter and a trigger detector
// assumes one instance per external input
`timescale 1ns/1ps
`default_nettype none
interface eint_if;
	logic tick;
	logic [7:0] thresh;
	logic level;
	logic ready;
	eint_pkg::trig_t trig;
	logic hit;
	modport filt(input tick, input thresh, output level, output ready);
	modport det(input level, input ready, input trig, output hit);
	modport ctl(output tick, output thresh, output trig, input hit);
endinterface
`default_nettype wire

// File: rtl/eint_noise_filter.sv
// two-flop synchroniser and digital noise filter for one pin
// assumes tick is high every cycle in normal modes, once per slow period otherwise
`timescale 1ns/1ps
`default_nettype none
module eint_noise_filter (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic pin,
	eint_if.filt lnk
);
	logic syncA_r;
	logic syncB_r;
	logic level_r;
	logic ready_r;
	logic [7:0] cnt_r;
	eint_pkg::prime_t prime_r;

	// pin crosses into clk_sys
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			syncA_r <= 1'b0;
			syncB_r <= 1'b0;
		end else begin
			syncA_r <= pin; // R18
			syncB_r <= syncA_r;
		end
	end

	// wait for the synchroniser to hold the real pin level
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			prime_r <= eint_pkg::PRIME0;
		end else begin
			unique case (prime_r)
				eint_pkg::PRIME0: prime_r <= eint_pkg::PRIME1;
				eint_pkg::PRIME1: prime_r <= eint_pkg::PRIME2;
				eint_pkg::PRIME2: prime_r <= eint_pkg::RUN;
				eint_pkg::RUN: prime_r <= eint_pkg::RUN;
			endcase
		end
	end

	// ready one cycle late so the detector has seen the primed level
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) ready_r <= 1'b0;
		else ready_r <= (prime_r == eint_pkg::RUN);
	end

	// once primed, level moves only after thresh differing samples in a row
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			level_r <= 1'b0;
			cnt_r <= 8'h00;
		end else if (prime_r != eint_pkg::RUN) begin
			level_r <= syncB_r;
			cnt_r <= 8'h00;
		end else if (lnk.tick) begin
			if (syncB_r == level_r) begin
				cnt_r <= 8'h00; // R1
			end else if (cnt_r + 8'h01 >= lnk.thresh) begin
				level_r <= syncB_r;
				cnt_r <= 8'h00;
			end else begin
				cnt_r <= cnt_r + 8'h01;
			end
		end
	end

	assign lnk.level = level_r;
	assign lnk.ready = ready_r;

	property p_filt_accept;
		@(posedge clk_sys) disable iff (!rst_b)
		(ready_r && $changed(level_r)) |-> ($past(cnt_r) + 8'h01 >= $past(lnk.thresh));
	endproperty
	a_filt_accept: assert property (p_filt_accept) else $error("level moved too early"); // R1

	property p_filt_reject;
		@(posedge clk_sys) disable iff (!rst_b)
		(prime_r == eint_pkg::RUN && lnk.tick && syncB_r != level_r
			&& cnt_r + 8'h01 < lnk.thresh) |=> (level_r == $past(level_r));
	endproperty
	a_filt_reject: assert property (p_filt_reject) else $error("short pulse passed"); // R2
endmodule
`default_nettype wire

// File: rtl/eint_pkg.sv
// constants and types for the external interrupt input block
// assumes clk_sys is the high speed clock, so fast clock periods equal clk_sys cycles
package eint_pkg;
	// ----------------------------------------
	// clocks
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int HS_CLOCK_HZ = 1000000000 / CLK_PERIOD_NS;
	localparam int LS_CLOCK_HZ = 32768;
	// low speed period in clk_sys cycles, rounded down
	localparam int LS_DIV_DEF = HS_CLOCK_HZ / LS_CLOCK_HZ;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] CTRL_ADDR = 8'h37;
	localparam logic [7:0] STATUS_ADDR = 8'h40;
	localparam logic [7:0] CLEAR_ADDR = 8'h41;
	localparam logic [7:0] ENABLE_ADDR = 8'h42;
	localparam logic [7:0] CFG_ADDR = 8'h43;

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int THRESH_SEL_BIT = 7;
	localparam int FIRST_SEL_BIT = 6;
	localparam int FIFTH_TRIG_LO = 4;
	localparam int FOURTH_EDGE_BIT = 3;
	localparam int THIRD_EDGE_BIT = 2;
	localparam int SECOND_EDGE_BIT = 1;
	localparam int SLOW_MODE_BIT = 0;
	localparam int GLOBAL_EN_BIT = 1;
	localparam int ROUTE_BIT = 2;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_MASK = 8'hFE;
	localparam logic [2:0] CFG_RESET = 3'h0;
	localparam int NUM_INPUTS = 6;

	// ----------------------------------------
	// rejection counts, in samples
	// ----------------------------------------
	localparam logic [7:0] REJ_FAST = 8'h02;
	localparam logic [7:0] REJ_MID = 8'h07;
	localparam logic [7:0] REJ_B_SHORT = 8'h0F;
	localparam logic [7:0] REJ_B_LONG = 8'h3F;
	localparam logic [7:0] REJ_SLOW = 8'h02;

	typedef enum logic [1:0] {
		TRIG_RISE = 2'b00,
		TRIG_FALL = 2'b01,
		TRIG_BOTH = 2'b10,
		TRIG_HIGH = 2'b11
	} trig_t;

	// gray sequence while the synchroniser fills after reset
	typedef enum logic [1:0] {
		PRIME0 = 2'b00,
		PRIME1 = 2'b01,
		PRIME2 = 2'b11,
		RUN = 2'b10
	} prime_t;
endpackage

// File: rtl/eint_trigger_detect.sv
// edge or level trigger on a filtered input
// assumes the filtered level and ready come from eint_noise_filter
`timescale 1ns/1ps
`default_nettype none
module eint_trigger_detect (
	input wire logic clk_sys,
	input wire logic rst_b,
	eint_if.det lnk
);
	logic prev_r;
	logic armed_r;
	logic hit_r;
	logic rise;
	logic fall;

	// output-driven pin changes are real edges here; software masks first  R14
	assign rise = lnk.ready & lnk.level & ~prev_r;
	assign fall = lnk.ready & ~lnk.level & prev_r;

	// previous level and arming for high level mode
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			prev_r <= 1'b0;
			armed_r <= 1'b0;
		end else begin
			prev_r <= lnk.level;
			if (rise) armed_r <= 1'b1; // R13
		end
	end

	// request for the selected trigger: one-cycle pulse per edge, held every cycle the level is high after the first rising edge in high level mode
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			hit_r <= 1'b0;
		end else begin
			unique case (lnk.trig)
				eint_pkg::TRIG_RISE: hit_r <= rise; // R11
				eint_pkg::TRIG_FALL: hit_r <= fall;
				eint_pkg::TRIG_BOTH: hit_r <= rise | fall;
				eint_pkg::TRIG_HIGH: hit_r <= lnk.ready & lnk.level & (armed_r | rise); // R13
			endcase
		end
	end

	assign lnk.hit = hit_r;

	property p_level_needs_rise;
		@(posedge clk_sys) disable iff (!rst_b)
		(lnk.trig == eint_pkg::TRIG_HIGH && !armed_r && !rise) |=> !hit_r;
	endproperty
	a_level_needs_rise: assert property (p_level_needs_rise) else $error("level hit unarmed"); // R13

	property p_fall_hit;
		@(posedge clk_sys) disable iff (!rst_b)
		(lnk.trig == eint_pkg::TRIG_FALL && fall) |=> hit_r;
	endproperty
	a_fall_hit: assert property (p_fall_hit) else $error("falling edge missed"); // R11

	c_level_hit: cover property (@(posedge clk_sys) disable iff (!rst_b)
		lnk.trig == eint_pkg::TRIG_HIGH && hit_r);
endmodule
`default_nettype wire

// File: rtl/ext_irq_inputs.sv
// top of the external interrupt input block: registers, filters, latches
// assumes clk_sys is the high speed clock and pins are asynchronous
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: six inputs, each noise filtered before any edge detection.
// R2: first and sixth: drop under 2 fast clocks, accept 7 or more.
// R3: second: reject under 15 or 63 clocks, accept 49 or 193.
// R4: third to fifth: reject under 7 clocks, accept 25 or more.
// R5: slow modes: reject under 1 slow period, accept 3.5 periods.
// R6: clean edge sets latch within filter time plus 6 slow periods.
// R7: first pin as port never sets its latch.
// R8: control bit 6 selects first pin role; port after reset.
// R9: control bit 7: 0 gives 63 clocks, 1 gives 15 clocks.
// R10: new second-input threshold applies within 64 fast clocks.
// R11: fifth trigger: 00 rise, 01 fall, 10 both, 11 high level.
// R12: second to fourth: 0 rising edge, 1 falling edge.
// R13: fifth high-level mode waits for a rising edge after reset.
// R14: output-driven shared pin may raise spurious request; mask first.
// R15: software disables interrupts while changing clock or control.
// R16: control register resets to zero, lowest bit don't care.
// R17: on acceptance clear global enable and the accepted latch.
// R18: every pin synchronised before filtering and edge detection.
module ext_irq_inputs #(
	parameter int LS_DIV = eint_pkg::LS_DIV_DEF
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic extIrqInA,
	input wire logic extIrqInB,
	input wire logic extIrqInC,
	input wire logic extIrqInD,
	input wire logic extIrqInE,
	input wire logic extIrqInF,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	input wire logic irqAccept,
	input wire logic [2:0] irqAcceptId,
	output logic irqOut,
	output logic firstPinIsIrq
);
	localparam int N = eint_pkg::NUM_INPUTS;
	localparam int DIV_W = $clog2(LS_DIV + 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(LS_DIV - 1);

	logic [7:0] ctrl_r;
	logic [2:0] cfg_r;
	logic [N-1:0] status_r;
	logic [N-1:0] enable_r;
	logic [N-1:0] hits;
	logic [N-1:0] setMask;
	logic [N-1:0] clrMask;
	logic [N-1:0] pins;
	logic [DIV_W-1:0] div_r;
	logic tick_r;
	logic [7:0] regRdData_r;
	logic irqOut_r;
	logic firstPinIsIrq_r;
	logic slowMode;
	logic globalIrqEnable;
	logic sixthLatchRouteBit;
	logic wrCtrl;
	logic wrClear;
	logic wrEnable;
	logic wrCfg;

	assign pins = {extIrqInF, extIrqInE, extIrqInD, extIrqInC, extIrqInB, extIrqInA};
	assign slowMode = cfg_r[eint_pkg::SLOW_MODE_BIT];
	assign globalIrqEnable = cfg_r[eint_pkg::GLOBAL_EN_BIT];
	assign sixthLatchRouteBit = cfg_r[eint_pkg::ROUTE_BIT];

	// ----------------------------------------
	// per-input settings
	// ----------------------------------------
	function automatic logic [7:0] threshFor(input int idx, input logic slow,
			input logic [7:0] ctrl);
		logic [7:0] t;
		t = eint_pkg::REJ_MID; // R4
		if (idx == 0 || idx == 5) t = eint_pkg::REJ_FAST; // R2
		if (idx == 1) begin
			t = ctrl[eint_pkg::THRESH_SEL_BIT] ? eint_pkg::REJ_B_SHORT
				: eint_pkg::REJ_B_LONG; // R3 R9
		end
		if (slow) t = eint_pkg::REJ_SLOW; // R5
		return t;
	endfunction

	function automatic eint_pkg::trig_t trigFor(input int idx, input logic [7:0] ctrl);
		eint_pkg::trig_t m;
		m = eint_pkg::TRIG_FALL;
		if (idx == 1) m = eint_pkg::trig_t'({1'b0, ctrl[eint_pkg::SECOND_EDGE_BIT]}); // R12
		if (idx == 2) m = eint_pkg::trig_t'({1'b0, ctrl[eint_pkg::THIRD_EDGE_BIT]});
		if (idx == 3) m = eint_pkg::trig_t'({1'b0, ctrl[eint_pkg::FOURTH_EDGE_BIT]});
		if (idx == 4) m = eint_pkg::trig_t'(ctrl[eint_pkg::FIFTH_TRIG_LO +: 2]); // R11
		return m;
	endfunction

	// ----------------------------------------
	// sample tick: every cycle, or once per slow period
	// ----------------------------------------
	// one divider serves all six filters, so they share sample phase
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			div_r <= '0;
			tick_r <= 1'b0;
		end else begin
			div_r <= (div_r == DIV_LAST) ? '0 : div_r + DIV_W'(1);
			tick_r <= !slowMode || (div_r == DIV_LAST); // R5
		end
	end

	// ----------------------------------------
	// filter and trigger per input
	// ----------------------------------------
	eint_if lnk[N] ();

	for (genvar i = 0; i < N; i++) begin : g_in
		// threshold follows the control bit on the next cycle  R10
		assign lnk[i].tick = tick_r;
		assign lnk[i].thresh = threshFor(i, slowMode, ctrl_r);
		assign lnk[i].trig = trigFor(i, ctrl_r);
		assign hits[i] = lnk[i].hit;

		eint_noise_filter u_filt (
			.clk_sys(clk_sys),
			.rst_b(rst_b),
			.pin(pins[i]),
			.lnk(lnk[i])
		);

		eint_trigger_detect u_det (
			.clk_sys(clk_sys),
			.rst_b(rst_b),
			.lnk(lnk[i])
		);
	end

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	assign wrCtrl = regWr && regAddr == eint_pkg::CTRL_ADDR;
	assign wrClear = regWr && regAddr == eint_pkg::CLEAR_ADDR;
	assign wrEnable = regWr && regAddr == eint_pkg::ENABLE_ADDR;
	assign wrCfg = regWr && regAddr == eint_pkg::CFG_ADDR;

	// control register; bit 0 is not stored
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) ctrl_r <= eint_pkg::CTRL_RESET; // R16 R8
		else if (wrCtrl) ctrl_r <= regWrData & eint_pkg::CTRL_MASK;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) enable_r <= '0;
		else if (wrEnable) enable_r <= regWrData[N-1:0];
	end

	// acceptance drops the global enable ahead of the vector fetch
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cfg_r <= eint_pkg::CFG_RESET;
		end else begin
			if (wrCfg) cfg_r <= regWrData[2:0];
			if (irqAccept) cfg_r[eint_pkg::GLOBAL_EN_BIT] <= 1'b0; // R17
		end
	end

	// ----------------------------------------
	// interrupt latches
	// ----------------------------------------
	// gating of the first and sixth sources before the latch
	always_comb begin
		setMask = hits; // R6
		setMask[0] = hits[0] & ctrl_r[eint_pkg::FIRST_SEL_BIT]; // R7
		setMask[5] = hits[5] & !sixthLatchRouteBit;
		clrMask = wrClear ? regWrData[N-1:0] : '0;
		if (irqAccept && int'(irqAcceptId) < N) clrMask[irqAcceptId] = 1'b1; // R17
	end

	// a set in the same cycle as a clear wins
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) status_r <= '0;
		else status_r <= (status_r & ~clrMask) | setMask;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irqOut_r <= 1'b0;
			firstPinIsIrq_r <= 1'b0;
		end else begin
			irqOut_r <= globalIrqEnable && |(status_r & enable_r);
			firstPinIsIrq_r <= ctrl_r[eint_pkg::FIRST_SEL_BIT]; // R8
		end
	end

	// read data stands in the cycle after the strobe only
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			regRdData_r <= 8'h00;
		end else if (regRd) begin
			unique case (regAddr)
				eint_pkg::CTRL_ADDR: regRdData_r <= ctrl_r;
				eint_pkg::STATUS_ADDR: regRdData_r <= {2'b00, status_r};
				eint_pkg::ENABLE_ADDR: regRdData_r <= {2'b00, enable_r};
				eint_pkg::CFG_ADDR: regRdData_r <= {5'b00000, cfg_r};
				default: regRdData_r <= 8'h00; // unmapped and write-only
			endcase
		end else begin
			regRdData_r <= 8'h00;
		end
	end

	assign regRdData = regRdData_r;
	assign irqOut = irqOut_r;
	assign firstPinIsIrq = firstPinIsIrq_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_ctrl_reset;
		@(posedge clk_sys) $rose(rst_b) |-> (ctrl_r == 8'h00 && !firstPinIsIrq_r);
	endproperty
	a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not reset"); // R16

	property p_port_no_latch;
		@(posedge clk_sys) disable iff (!rst_b)
		(!ctrl_r[eint_pkg::FIRST_SEL_BIT] && !status_r[0] && !wrCtrl) |=> !status_r[0];
	endproperty
	a_port_no_latch: assert property (p_port_no_latch) else $error("port set latch"); // R7

	property p_hit_latches;
		@(posedge clk_sys) disable iff (!rst_b)
		(hits[2] || hits[3] || hits[4]) |=> (status_r[4:2] & $past(hits[4:2])) == $past(hits[4:2]);
	endproperty
	a_hit_latches: assert property (p_hit_latches) else $error("edge not latched"); // R6

	property p_accept_clears;
		@(posedge clk_sys) disable iff (!rst_b)
		(irqAccept && int'(irqAcceptId) < N && !setMask[irqAcceptId])
			|=> (!globalIrqEnable && !status_r[$past(irqAcceptId)]);
	endproperty
	a_accept_clears: assert property (p_accept_clears) else $error("accept not cleared"); // R17

	property p_thresh_b;
		@(posedge clk_sys) disable iff (!rst_b)
		!slowMode |-> lnk[1].thresh == (ctrl_r[eint_pkg::THRESH_SEL_BIT]
			? eint_pkg::REJ_B_SHORT : eint_pkg::REJ_B_LONG);
	endproperty
	a_thresh_b: assert property (p_thresh_b) else $error("second threshold wrong"); // R9

	property p_thresh_follow;
		@(posedge clk_sys) disable iff (!rst_b)
		(wrCtrl && !slowMode && !wrCfg) |=> lnk[1].thresh
			== ($past(regWrData[eint_pkg::THRESH_SEL_BIT]) ? eint_pkg::REJ_B_SHORT
			: eint_pkg::REJ_B_LONG);
	endproperty
	a_thresh_follow: assert property (p_thresh_follow) else $error("threshold late"); // R10

	property p_slow_thresh;
		@(posedge clk_sys) disable iff (!rst_b)
		slowMode |-> (lnk[0].thresh == eint_pkg::REJ_SLOW && lnk[1].thresh == eint_pkg::REJ_SLOW
			&& lnk[4].thresh == eint_pkg::REJ_SLOW);
	endproperty
	a_slow_thresh: assert property (p_slow_thresh) else $error("slow threshold wrong"); // R5

	property p_fast_thresh;
		@(posedge clk_sys) disable iff (!rst_b)
		!slowMode |-> (lnk[0].thresh == eint_pkg::REJ_FAST && lnk[5].thresh == eint_pkg::REJ_FAST
			&& lnk[3].thresh == eint_pkg::REJ_MID);
	endproperty
	a_fast_thresh: assert property (p_fast_thresh) else $error("fast threshold wrong"); // R4

	property p_trig_map;
		@(posedge clk_sys) disable iff (!rst_b)
		(lnk[4].trig == ctrl_r[eint_pkg::FIFTH_TRIG_LO +: 2])
			&& (lnk[2].trig == {1'b0, ctrl_r[eint_pkg::THIRD_EDGE_BIT]});
	endproperty
	a_trig_map: assert property (p_trig_map) else $error("trigger map wrong"); // R12

	property p_irq_out;
		@(posedge clk_sys) disable iff (!rst_b)
		(globalIrqEnable && |(status_r & enable_r)) |=> irqOut_r;
	endproperty
	a_irq_out: assert property (p_irq_out) else $error("interrupt not raised");

	// read data must not linger once its one cycle is over
	property p_rd_idle;
		@(posedge clk_sys) disable iff (!rst_b)
		!regRd |=> regRdData_r == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data lingered");

	// a latch set beside a clear of the same bit must survive
	property p_set_wins;
		@(posedge clk_sys) disable iff (!rst_b)
		|(setMask & clrMask) |=> (status_r & $past(setMask)) == $past(setMask);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat a set"); // R6

	c_first_latch: cover property (@(posedge clk_sys) disable iff (!rst_b) setMask[0]);
	c_second_latch: cover property (@(posedge clk_sys) disable iff (!rst_b) setMask[1]);
	c_accept: cover property (@(posedge clk_sys) disable iff (!rst_b) irqAccept && irqOut_r);
	c_set_clear: cover property (@(posedge clk_sys) disable iff (!rst_b)
		|(setMask & clrMask));
endmodule
`default_nettype wire

// File: verif/pin_source_model.sv
// board-side sources that drive the six external interrupt pins
// assumes the bench calls its tasks from code aligned to clk_sys
`timescale 1ns/1ps
`default_nettype none
module pin_source_model (
	input wire logic clk_sys,
	output var logic [5:0] pins
);
	// idle high, the quiet level of the falling-edge inputs
	initial begin
		pins = 6'h3F;
	end

	// step one pin to a new level and leave it there
	task automatic setLevel(input int idx, input logic lvl);
		@(posedge clk_sys);
		pins[idx] <= lvl;
	endtask

	// inverted pulse of a set number of cycles, then back to the old level
	task automatic pulse(input int idx, input int width);
		logic old;
		old = pins[idx];
		@(posedge clk_sys);
		pins[idx] <= ~old;
		repeat (width) @(posedge clk_sys);
		pins[idx] <= old;
	endtask
endmodule
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the external interrupt input block
// assumes the package, interface, design files and pin source model come first
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int LSD = 4;
	// long enough for the slowest filter to settle back after a pulse
	localparam int SETTLE = 80;
	logic clk_sys;
	logic rst_b;
	logic [5:0] pins;
	logic [7:0] regAddr;
	logic [7:0] regWrData;
	logic regWr;
	logic regRd;
	logic [7:0] regRdData;
	logic irqAccept;
	logic [2:0] irqAcceptId;
	logic irqOut;
	logic firstPinIsIrq;
	int failures;
	int checks_done;
	int seed;
	int r;
	int w;

	pin_source_model src_u (.clk_sys(clk_sys), .pins(pins));
	ext_irq_inputs #(.LS_DIV(LSD)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
		.extIrqInA(pins[0]), .extIrqInB(pins[1]), .extIrqInC(pins[2]),
		.extIrqInD(pins[3]), .extIrqInE(pins[4]), .extIrqInF(pins[5]),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .irqAccept(irqAccept), .irqAcceptId(irqAcceptId),
		.irqOut(irqOut), .firstPinIsIrq(firstPinIsIrq));

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// ----------------------------------------
	// expectations and bus tasks
	// ----------------------------------------
	// shortest accepted and longest rejected pulse per input, in cycles
	function automatic int acceptLen(input int idx, input logic fastB);
		if (idx == 0 || idx == 5) return 7;
		if (idx == 1) return fastB ? 49 : 193;
		return 25;
	endfunction
	function automatic int rejectLen(input int idx, input logic fastB);
		if (idx == 0 || idx == 5) return 1;
		if (idx == 1) return fastB ? 14 : 62;
		return 6;
	endfunction
	function automatic logic [7:0] bitOf(input int idx, input logic on);
		return on ? (8'h01 << idx) : 8'h00;
	endfunction

	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask
	// data stand only in the cycle after the strobe, sampled once it settles
	task automatic expectReg(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge clk_sys);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1;
		check(regRdData, exp, what);
	endtask
	task automatic clearAll();
		regWrite(eint_pkg::CLEAR_ADDR, 8'h3F);
	endtask
	task automatic pulseCheck(input int idx, input int width, input logic hit);
		clearAll();
		src_u.pulse(idx, width);
		repeat (SETTLE) @(posedge clk_sys);
		expectReg(eint_pkg::STATUS_ADDR, bitOf(idx, hit), "latch after pulse");
	endtask
	task automatic stepCheck(input int idx, input logic lvl, input logic hit);
		clearAll();
		src_u.setLevel(idx, lvl);
		repeat (SETTLE) @(posedge clk_sys);
		expectReg(eint_pkg::STATUS_ADDR, bitOf(idx, hit), "latch after step");
	endtask
	// bounded wait on the interrupt level; running out ends the run
	task automatic waitIrq(input logic exp);
		int n;
		n = 0;
		while (irqOut !== exp && n < 8) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		check({7'h00, irqOut}, {7'h00, exp}, "interrupt level");
		if (irqOut !== exp) conclude();
	endtask
	task automatic endTest(input string name);
		$display("test %s finished, mismatches so far %0d", name, failures);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		seed = 39;
		failures = 0;
		checks_done = 0;
		rst_b = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		irqAccept = 1'b0;
		irqAcceptId = 3'h0;
		repeat (20) @(posedge clk_sys);
		rst_b <= 1'b1;
		// filters load the pin level first, so let them prime
		repeat (8) @(posedge clk_sys);
		expectReg(eint_pkg::CTRL_ADDR, eint_pkg::CTRL_RESET, "control reset");
		check({7'h00, firstPinIsIrq}, 8'h00, "first pin role after reset");
		expectReg(eint_pkg::CFG_ADDR, 8'h00, "cfg reset");
		expectReg(8'h00, 8'h00, "unmapped read");
		pulseCheck(0, 20, 1'b0);
		// fifth input sits high since reset, so high level must stay quiet
		regWrite(eint_pkg::CTRL_ADDR, 8'hFF);
		expectReg(eint_pkg::CTRL_ADDR, eint_pkg::CTRL_MASK, "control bit zero");
		check({7'h00, firstPinIsIrq}, 8'h01, "first pin role");
		repeat (SETTLE) @(posedge clk_sys);
		expectReg(eint_pkg::STATUS_ADDR, 8'h00, "no request before rise");
		expectReg(eint_pkg::CLEAR_ADDR, 8'h00, "clear reads zero");
		endTest("registers");

		// all falling edges, short threshold on the second input
		regWrite(eint_pkg::CTRL_ADDR, 8'hDE);
		repeat (64) @(posedge clk_sys);
		for (int i = 0; i < 6; i++) begin
			pulseCheck(i, rejectLen(i, 1'b1), 1'b0);
			pulseCheck(i, acceptLen(i, 1'b1), 1'b1);
		end
		regWrite(eint_pkg::CTRL_ADDR, 8'h5E);
		repeat (64) @(posedge clk_sys);
		pulseCheck(1, rejectLen(1, 1'b0), 1'b0);
		pulseCheck(1, acceptLen(1, 1'b0), 1'b1);
		endTest("filters");

		// rising edges for the second to fourth inputs, every trigger mode for the fifth
		regWrite(eint_pkg::CTRL_ADDR, 8'h40);
		for (int i = 1; i < 4; i++) begin
			stepCheck(i, 1'b0, 1'b0);
			stepCheck(i, 1'b1, 1'b1);
		end
		for (int m = 0; m < 4; m++) begin
			regWrite(eint_pkg::CTRL_ADDR, 8'h40 | 8'(m << 4));
			stepCheck(4, 1'b0, m != 0);
			clearAll();
			repeat (8) @(posedge clk_sys);
			expectReg(eint_pkg::STATUS_ADDR, 8'h00, "quiet while low");
			stepCheck(4, 1'b1, m != 1);
			clearAll();
			repeat (8) @(posedge clk_sys);
			expectReg(eint_pkg::STATUS_ADDR, bitOf(4, m == 3), "level repeats");
		end
		endTest("triggers");

		// enable, mask, clear and acceptance
		regWrite(eint_pkg::CTRL_ADDR, 8'hDE);
		pulseCheck(2, 25, 1'b1);
		waitIrq(1'b0);
		regWrite(eint_pkg::ENABLE_ADDR, 8'h04);
		regWrite(eint_pkg::CFG_ADDR, 8'h02);
		waitIrq(1'b1);
		expectReg(eint_pkg::ENABLE_ADDR, 8'h04, "enable readback");
		regWrite(eint_pkg::ENABLE_ADDR, 8'h00);
		waitIrq(1'b0);
		regWrite(eint_pkg::ENABLE_ADDR, 8'h04);
		waitIrq(1'b1);
		regWrite(eint_pkg::CLEAR_ADDR, 8'h04);
		waitIrq(1'b0);
		src_u.pulse(2, 30);
		waitIrq(1'b1);
		repeat (SETTLE) @(posedge clk_sys);
		waitIrq(1'b1);
		@(posedge clk_sys);
		irqAccept <= 1'b1;
		irqAcceptId <= 3'h2;
		@(posedge clk_sys);
		irqAccept <= 1'b0;
		expectReg(eint_pkg::STATUS_ADDR, 8'h00, "accepted latch cleared");
		expectReg(eint_pkg::CFG_ADDR, 8'h00, "global enable cleared");
		waitIrq(1'b0);
		endTest("interrupts");

		// slow sampling, then the sixth input routed away
		regWrite(eint_pkg::ENABLE_ADDR, 8'h00);
		regWrite(eint_pkg::CFG_ADDR, 8'h01);
		pulseCheck(0, LSD - 1, 1'b0);
		pulseCheck(0, (7 * LSD + 1) / 2, 1'b1);
		regWrite(eint_pkg::CFG_ADDR, 8'h04);
		pulseCheck(5, 7, 1'b0);
		regWrite(eint_pkg::CFG_ADDR, 8'h00);
		endTest("slow mode");

		// random widths away from the undefined band between limits
		repeat (8) begin
			r = $random(seed);
			w = r[8] ? 1 + (r[3:0] % 6) : 25 + r[3:0];
			pulseCheck(3, w, w >= 25);
		end
		endTest("random");
		conclude();
	end

	// watchdog against a hang anywhere in the sequence
	initial begin
		repeat (100000) @(posedge clk_sys);
		failures++;
		$display("wrong value at %0t: run did not finish", $time);
		conclude();
	end
endmodule
`default_nettype wire
